/* File: common/link_ctl_pkg.sv */
// Shared constants, field positions and types for the link core control registers
package link_ctl_pkg;

    // Register byte offsets inside the window
    localparam logic [7:0] FAIRNESS_OFFSET     = 8'hDC;
    localparam logic [7:0] LINK_SET_OFFSET     = 8'hE0;
    localparam logic [7:0] LINK_CLEAR_OFFSET   = 8'hE4;
    localparam logic [7:0] TIMER_STATUS_OFFSET = 8'hF0;
    localparam logic [7:0] IR_FILTER_OFFSET    = 8'hF4;

    // Link control field positions
    localparam int ROLLOVER_SRC_BIT  = 22;
    localparam int CYCLE_MASTER_BIT  = 21;
    localparam int TIMER_ENABLE_BIT  = 20;
    localparam int PHY_RECEIVE_BIT   = 10;
    localparam int SELF_ID_BIT       = 9;
    localparam int FILTER_LOCK_BIT   = 6;

    // Fairness field width and reset values
    localparam int         FAIRNESS_WIDTH = 8;
    localparam logic [7:0] FAIRNESS_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET    = 6'h00;

    // Word-size transfer code
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Timing: clock rates in kHz and the cycle period in microseconds
    localparam int REF_CLK_KHZ     = 125000;
    localparam int TIMER_CLK_KHZ   = 24576;
    localparam int CYCLE_PERIOD_US = 125;
    localparam int CYCLE_TICKS     = CYCLE_PERIOD_US * TIMER_CLK_KHZ / 1000;
    localparam int OFFSET_WIDTH    = 12;
    localparam int ACC_WIDTH       = 17;

    // Control flags as seen by the rest of the link
    typedef struct packed {
        logic rollover_source_select;
        logic cycle_master_enable;
        logic timer_count_enable;
        logic phy_packet_receive_enable;
        logic self_id_receive_enable;
        logic tag_one_filter_lock;
    } link_flags_type;

    // Bus slave phases, Gray coded along idle, read wait, read done
    typedef enum logic [1:0] {
        BUS_IDLE      = 2'b00,
        BUS_READ_WAIT = 2'b01,
        BUS_READ_DONE = 2'b11,
        BUS_WRITE     = 2'b10
    } bus_state_type;

endpackage

/* File: core/link_core_control_regs.sv */
// Link core control registers: fairness limit, link control flags and cycle timer
// What this block does
// - Eight-bit limit caps priority asynchronous requests per fairness interval.
// - Fairness bits 31 to 8 always read as zero.
// - Rollover source set means timer rolls over on external cycle input.
// - Rollover source clear means rollover after 3072 timer clocks, 125 us.
// - Cycle master sends a cycle start at every rollover.
// - Without cycle master, received cycle starts resynchronise the timer.
// - Overlong cycle event clears cycle master automatically.
// - Setting cycle master is ignored while overlong cycle event is set.
// - Timer offset counts and rolls over only while timer enable is set.
// - PHY receive bit passes PHY packets to enabled async receive context.
// - PHY receive bit has no effect on self-ID packet reception.
// - Self-ID receive bit lets incoming self-ID packets be accepted.
// - Filter lock forces every context tag-one sync filter bit to one.
// - Without lock, software reads and writes each context filter bit.
// - Filter lock is set-only; only global reset clears it.
// - Link control has set address E0h, clear address E4h, both readable.
// - Reserved link control bits read as zero.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module link_core_control_regs #(
    parameter int IR_CONTEXTS = 4
) (
    input  wire logic                               ref_clk,
    input  wire logic                               srst,
    input  wire logic                               global_reset,
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic                                    hreadyout,
    output logic [31:0]                             hrdata,
    output logic                                    hresp,
    input  wire logic                               external_cycle_input,
    input  wire logic                               overlong_cycle_event,
    input  wire logic                               cycle_start_received,
    input  wire logic                               async_receive_context_enable,
    input  wire logic                               phy_packet_arrive,
    input  wire logic                               self_id_packet_arrive,
    output logic                                    phy_packet_store,
    output logic                                    self_id_packet_store,
    input  wire logic                               priority_request_want,
    input  wire logic                               fairness_interval_start,
    output logic                                    priority_request_grant,
    output logic                                    cycle_start_send,
    output logic [link_ctl_pkg::OFFSET_WIDTH-1:0]   cycle_offset,
    output link_ctl_pkg::link_flags_type            link_flags,
    output logic [IR_CONTEXTS-1:0]                  tag_one_sync_filter
);
    import link_ctl_pkg::*;

    // Set/clear update of one flag
    // set and clear
    function automatic logic apply_set_clear(input logic cur, input logic set, input logic clr);
        apply_set_clear = (cur | set) & ~clr;
    endfunction

    // Bus phase tracking
    bus_state_type          state_q;
    bus_state_type          state_d;
    logic [7:0]             addr_q;
    logic                   word_q;
    logic [31:0]            hrdata_q;

    // Control state
    logic [FAIRNESS_WIDTH-1:0] limit_q;
    logic [FAIRNESS_WIDTH-1:0] grant_count_q;
    logic                   src_q;
    logic                   master_q;
    logic                   enable_q;
    logic                   phy_en_q;
    logic                   sid_en_q;
    logic                   lock_q;
    logic [IR_CONTEXTS-1:0] filter_q;

    // Timer state
    logic [ACC_WIDTH-1:0]   acc_q;
    logic [OFFSET_WIDTH-1:0] offset_q;
    logic [OFFSET_WIDTH-1:0] offset_d;
    logic                   ext_s1_q;
    logic                   ext_s2_q;
    logic                   ext_s3_q;
    logic                   ext_level_q;
    logic                   start_send_q;
    logic                   phy_store_q;
    logic                   sid_store_q;

    // Address phase decode; sampled hready is the single slave's own ready
    wire        accept   = hsel && htrans[1] && hready;
    wire        wr_go    = (state_q == BUS_WRITE) && word_q;
    wire        set_hit  = wr_go && (addr_q == LINK_SET_OFFSET);
    wire        clr_hit  = wr_go && (addr_q == LINK_CLEAR_OFFSET);
    wire        fair_hit = wr_go && (addr_q == FAIRNESS_OFFSET);
    wire        filt_hit = wr_go && (addr_q == IR_FILTER_OFFSET);

    // Next bus phase; a new address phase may follow any completed one
    always_comb begin
        state_d = BUS_IDLE;
        unique case (state_q)
            BUS_READ_WAIT: state_d = BUS_READ_DONE;
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                if (accept) begin
                    state_d = hwrite ? BUS_WRITE : BUS_READ_WAIT;
                end
            end
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    assign hreadyout = (state_q != BUS_READ_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= BUS_IDLE;
            addr_q  <= 8'h00;
            word_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            if (accept) begin
                addr_q <= haddr[7:0];
                word_q <= (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h000000);
            end
        end
    end

    // Read assembly; reserved bits and unmapped offsets give zero
    wire [31:0] link_word;
    wire [31:0] read_word;
    wire [IR_CONTEXTS-1:0] filter_view;
    assign filter_view = filter_q | {IR_CONTEXTS{lock_q}};
    assign link_word = {9'h000, src_q, master_q, enable_q, 9'h000, phy_en_q, sid_en_q,
                        2'h0, lock_q, 6'h00};
    assign read_word = !word_q ? 32'h00000000 :
                       (addr_q == FAIRNESS_OFFSET)     ? {24'h000000, limit_q} :
                       (addr_q == LINK_SET_OFFSET)     ? link_word :
                       (addr_q == LINK_CLEAR_OFFSET)   ? link_word :
                       (addr_q == TIMER_STATUS_OFFSET) ? {20'h00000, offset_q} :
                       (addr_q == IR_FILTER_OFFSET)    ? 32'(filter_view) :
                       32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hrdata_q <= 32'h00000000;
        end else if (state_q == BUS_READ_WAIT) begin
            hrdata_q <= read_word;
        end
    end

    // Fairness limit and filter bits written as plain registers
    // filter read write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            limit_q  <= FAIRNESS_RESET;
            filter_q <= '0;
        end else begin
            if (fair_hit) begin
                limit_q <= hwdata[FAIRNESS_WIDTH-1:0];
            end
            if (filt_hit) begin
                filter_q <= hwdata[IR_CONTEXTS-1:0];
            end
        end
    end

    // Link control flags through set and clear ports
    wire master_set = set_hit && hwdata[CYCLE_MASTER_BIT];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {src_q, master_q, enable_q, phy_en_q, sid_en_q} <= FLAGS_RESET[4:0];
        end else begin
            src_q    <= apply_set_clear(src_q, set_hit && hwdata[ROLLOVER_SRC_BIT],
                                        clr_hit && hwdata[ROLLOVER_SRC_BIT]);
            enable_q <= apply_set_clear(enable_q, set_hit && hwdata[TIMER_ENABLE_BIT],
                                        clr_hit && hwdata[TIMER_ENABLE_BIT]);
            phy_en_q <= apply_set_clear(phy_en_q, set_hit && hwdata[PHY_RECEIVE_BIT],
                                        clr_hit && hwdata[PHY_RECEIVE_BIT]);
            sid_en_q <= apply_set_clear(sid_en_q, set_hit && hwdata[SELF_ID_BIT],
                                        clr_hit && hwdata[SELF_ID_BIT]);
            master_q <= overlong_cycle_event ? 1'b0 :
                        apply_set_clear(master_q, master_set,
                                        clr_hit && hwdata[CYCLE_MASTER_BIT]);
        end
    end

    // Lock survives the ordinary reset and the clear port on purpose
    // set only lock
    always_ff @(posedge ref_clk) begin
        if (global_reset) begin
            lock_q <= 1'b0;
        end else if (set_hit && hwdata[FILTER_LOCK_BIT]) begin
            lock_q <= 1'b1;
        end
    end

    // Fractional divider: one enable per timer clock on average, jitter one ref cycle
    wire [ACC_WIDTH:0] acc_sum = {1'b0, acc_q} + (ACC_WIDTH+1)'(TIMER_CLK_KHZ);
    wire               tick    = acc_sum >= (ACC_WIDTH+1)'(REF_CLK_KHZ);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acc_q <= '0;
        end else begin
            acc_q <= tick ? ACC_WIDTH'(acc_sum - (ACC_WIDTH+1)'(REF_CLK_KHZ))
                          : acc_sum[ACC_WIDTH-1:0];
        end
    end

    // External cycle pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_s1_q    <= 1'b0;
            ext_s2_q    <= 1'b0;
            ext_s3_q    <= 1'b0;
            ext_level_q <= 1'b0;
        end else begin
            ext_s1_q <= external_cycle_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            if (ext_s2_q == ext_s3_q) begin
                ext_level_q <= ext_s3_q;
            end
        end
    end
    wire ext_edge = (ext_s2_q == ext_s3_q) && ext_s3_q && !ext_level_q;

    // Rollover selection
    // internal 3072 count
    wire int_roll = tick && (offset_q == OFFSET_WIDTH'(CYCLE_TICKS - 1));
    wire rollover = enable_q && (src_q ? ext_edge : int_roll);

    // Offset counter
    // count only enabled
    always_comb begin
        offset_d = offset_q;
        if (enable_q) begin
            if (rollover) begin
                offset_d = '0;
            end else if (!master_q && cycle_start_received) begin
                offset_d = '0;
            end else if (tick) begin
                offset_d = offset_q + OFFSET_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            offset_q     <= '0;
            start_send_q <= 1'b0;
        end else begin
            offset_q     <= offset_d;
            start_send_q <= rollover && master_q;
        end
    end

    // Packet gating; the two receive controls are independent
    // PHY packet gate
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phy_store_q <= 1'b0;
            sid_store_q <= 1'b0;
        end else begin
            phy_store_q <= phy_packet_arrive && phy_en_q && async_receive_context_enable;
            sid_store_q <= self_id_packet_arrive && sid_en_q;
        end
    end

    // Priority request budget per fairness interval
    // request limit
    assign priority_request_grant = priority_request_want && (grant_count_q < limit_q);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            grant_count_q <= '0;
        end else if (fairness_interval_start) begin
            grant_count_q <= '0;
        end else if (priority_request_grant) begin
            grant_count_q <= grant_count_q + FAIRNESS_WIDTH'(1);
        end
    end

    // Outputs
    assign phy_packet_store     = phy_store_q;
    assign self_id_packet_store = sid_store_q;
    assign cycle_start_send     = start_send_q;
    assign cycle_offset         = offset_q;
    assign tag_one_sync_filter  = filter_view;
    assign link_flags           = '{rollover_source_select:    src_q,
                                    cycle_master_enable:       master_q,
                                    timer_count_enable:        enable_q,
                                    phy_packet_receive_enable: phy_en_q,
                                    self_id_receive_enable:    sid_en_q,
                                    tag_one_filter_lock:       lock_q};

    // Checks
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence s_read_done_at(logic [7:0] off);
        (state_q == BUS_READ_DONE) && word_q && (addr_q == off);
    endsequence
    sequence s_master_set_while_overlong;
        overlong_cycle_event && set_hit && hwdata[CYCLE_MASTER_BIT];
    endsequence

    chk_grant_within_limit: assert property (
        priority_request_grant |-> (grant_count_q < limit_q) ##1
        (grant_count_q <= limit_q) || $past(fairness_interval_start) || $past(fair_hit))
        else $error("priority grant beyond fairness limit");
    chk_fairness_reserved: assert property (
        s_read_done_at(FAIRNESS_OFFSET) |-> hrdata[31:8] == 24'h000000)
        else $error("fairness reserved bits not zero");
    chk_ext_rollover_zero: assert property (
        enable_q && src_q && ext_edge |=> offset_q == '0)
        else $error("external rollover did not zero offset");
    chk_internal_rollover: assert property (
        enable_q && !src_q && tick && offset_q == OFFSET_WIDTH'(CYCLE_TICKS - 1)
        |=> offset_q == '0 && !src_q)
        else $error("internal rollover not at 3072");
    chk_master_start_send: assert property (
        rollover && master_q |=> cycle_start_send ##1 !cycle_start_send)
        else $error("cycle start not sent on rollover");
    chk_slave_resync: assert property (
        enable_q && !master_q && cycle_start_received && !tick |=> offset_q == '0)
        else $error("received cycle start did not resync");
    chk_overlong_clears: assert property (
        overlong_cycle_event |=> !link_flags.cycle_master_enable)
        else $error("overlong cycle did not clear master");
    chk_master_set_blocked: assert property (
        s_master_set_while_overlong |=> !master_q)
        else $error("master set while overlong event active");
    chk_timer_hold: assert property (
        !enable_q |=> $stable(cycle_offset))
        else $error("offset moved while timer disabled");
    chk_phy_gate: assert property (
        phy_packet_store |-> $past(phy_packet_arrive && async_receive_context_enable && phy_en_q))
        else $error("PHY packet stored without enables");
    chk_self_id_gate: assert property (
        self_id_packet_arrive && sid_en_q |=> self_id_packet_store)
        else $error("self-ID packet not accepted");
    chk_tag_force: assert property (
        lock_q |-> &tag_one_sync_filter)
        else $error("filter bits not forced under lock");
    chk_lock_sticky: assert property (
        lock_q && !global_reset |=> lock_q)
        else $error("filter lock cleared without global reset");
    chk_link_reserved: assert property (
        s_read_done_at(LINK_SET_OFFSET) or s_read_done_at(LINK_CLEAR_OFFSET)
        |-> hrdata[31:23] == 9'h000 && hrdata[19:11] == 9'h000 && hrdata[5:0] == 6'h00)
        else $error("link control reserved bits not zero");

endmodule

`default_nettype wire

/* File: verif/link_far_side_model.sv */
// Far-side model: packet arrivals and arbitration traffic of the link logic
`timescale 1ns/1ps
`default_nettype none

module link_far_side_model (
    input  wire logic ref_clk,
    output logic      phy_packet_arrive,
    output logic      self_id_packet_arrive,
    output logic      async_receive_context_enable,
    output logic      priority_request_want,
    output logic      fairness_interval_start
);
    int         seed;
    logic [7:0] rv;

    // Quiet lines until the first edge
    initial begin
        seed = 46813;
        phy_packet_arrive = 1'b0;
        self_id_packet_arrive = 1'b0;
        async_receive_context_enable = 1'b0;
        priority_request_want = 1'b0;
        fairness_interval_start = 1'b0;
    end

    // Fresh traffic just after each edge; a restart never meets a request
    always @(posedge ref_clk) begin
        rv = 8'($random(seed));
        phy_packet_arrive <= rv[0] & rv[1];
        self_id_packet_arrive <= rv[2] & rv[3];
        async_receive_context_enable <= rv[4] | rv[5];
        fairness_interval_start <= (rv[7:3] == 5'h00);
        priority_request_want <= rv[6] & (rv[7:3] != 5'h00);
    end
endmodule
`default_nettype wire

/* File: verif/link_core_control_regs_tb.sv */
// Self-checking bench for the link core control registers
`timescale 1ns/1ps
`default_nettype none

module link_core_control_regs_tb;
    import link_ctl_pkg::*;
    localparam logic [31:0] RSV = 32'hFF8FF9BF;
    logic        ref_clk, srst, global_reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r, e;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        ext_in, ovl, cs_rx, rx_ctx_en, phy_in, sid_in, want, fstart;
    logic        phy_st, sid_st, grant, cs_send, p_phy, p_sid, p_ten, p_rst;
    logic [11:0] off, p_off;
    link_flags_type flags;
    logic [3:0]  filt, m_filt;
    logic [5:0]  m_fl;
    logic [7:0]  m_lim;
    int          n_errors, n_tests, seed, cnt, cyc, n_wrap, n_send, per, since, w0, s0;

    link_core_control_regs link_core_control_regs_inst (
        .ref_clk(ref_clk), .srst(srst), .global_reset(global_reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .external_cycle_input(ext_in), .overlong_cycle_event(ovl),
        .cycle_start_received(cs_rx), .async_receive_context_enable(rx_ctx_en),
        .phy_packet_arrive(phy_in), .self_id_packet_arrive(sid_in),
        .phy_packet_store(phy_st), .self_id_packet_store(sid_st),
        .priority_request_want(want), .fairness_interval_start(fstart),
        .priority_request_grant(grant), .cycle_start_send(cs_send), .cycle_offset(off),
        .link_flags(flags), .tag_one_sync_filter(filt));

    link_far_side_model link_far_side_model_inst (
        .ref_clk(ref_clk), .phy_packet_arrive(phy_in), .self_id_packet_arrive(sid_in),
        .async_receive_context_enable(rx_ctx_en), .priority_request_want(want),
        .fairness_interval_start(fstart));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] fl2w(input logic [5:0] f);
        return {9'h0, f[5:3], 9'h0, f[2:1], 2'h0, f[0], 6'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d of %0d comparisons", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Single word transfer: hold the address phase, then the data phase, until ready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Model follows at the same edge the write lands; set of master loses to overlong
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        if (a == FAIRNESS_OFFSET) m_lim <= d[7:0];
        if (a == LINK_SET_OFFSET) m_fl <= m_fl | ({d[22:20], d[10:9], d[6]} & {1'b1, ~ovl, 4'hF});
        if (a == LINK_CLEAR_OFFSET) m_fl <= m_fl & ~({d[22:20], d[10:9], d[6]} & 6'h3E);
        if (a == IR_FILTER_OFFSET) m_filt <= d[3:0];
    endtask

    task automatic rd_chk(input logic [7:0] a);
        ahb(1'b0, a, 32'h0);
        if (a == FAIRNESS_OFFSET) e = {24'h0, m_lim};
        else if (a == LINK_SET_OFFSET || a == LINK_CLEAR_OFFSET) e = fl2w(m_fl);
        else if (a == IR_FILTER_OFFSET) e = {28'h0, m_filt | {4{m_fl[0]}}};
        else e = 32'h0;
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Run limit; a hang counts as a mismatch and closes the run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 50000) begin
            n_errors++;
            $display("[ERR] t=%0t run limit reached", $time);
            end_sim();
        end
    end

    // Per-cycle comparison of store, grant, flag and filter outputs, and of the offset while the timer is disabled, against the model
    always @(posedge ref_clk) begin
        if (!srst && !p_rst) begin
            chk({31'h0, phy_st}, {31'h0, p_phy});
            chk({31'h0, sid_st}, {31'h0, p_sid});
            chk({31'h0, grant}, {31'h0, want && cnt < m_lim});
            chk({26'h0, flags}, {26'h0, m_fl});
            chk({28'h0, filt}, {28'h0, m_filt | {4{m_fl[0]}}});
            if (!m_fl[3] && !p_ten) chk({20'h0, off}, {20'h0, p_off});
            if (off == 12'h000 && p_off != 12'h000) begin
                n_wrap++;
                per = since;
                since = 0;
            end
        end
        since++;
        n_send += int'(cs_send);
        p_phy <= phy_in & m_fl[2] & rx_ctx_en;
        p_sid <= sid_in & m_fl[1];
        p_off <= off;
        p_ten <= m_fl[3];
        p_rst <= srst;
        if (srst || fstart) cnt <= 0;
        else if (want && cnt < m_lim) cnt <= cnt + 1;
        if (srst || global_reset) m_fl <= m_fl & {srst ? 5'h00 : 5'h1F, ~global_reset};
        if (srst) m_lim <= 8'h00;
        if (srst) m_filt <= 4'h0;
    end

    initial begin
        {n_errors, n_tests, cnt, cyc, n_wrap, n_send, per, since} = '0;
        seed = 46813;
        {srst, global_reset} = 2'b11;
        {hsel, hwrite, ext_in, ovl, cs_rx, p_phy, p_sid, p_ten, p_rst} = '0;
        {haddr, hwdata, htrans, hsize, p_off, m_fl, m_lim, m_filt} = '0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        global_reset <= 1'b0;
        @(posedge ref_clk);
        foreach (e[i]) if (i < 5) rd_chk(8'hDC + 8'(i * 4));
        rd_chk(8'hE8);
        for (int k = 0; k < 4; k++) begin
            wr(FAIRNESS_OFFSET, $random(seed));
            rd_chk(FAIRNESS_OFFSET);
        end
        wr(FAIRNESS_OFFSET, 32'hFFFFFF03);
        wr(IR_FILTER_OFFSET, 32'h00000005);
        rd_chk(IR_FILTER_OFFSET);
        for (int i = 0; i < 6; i++) begin
            wr(LINK_SET_OFFSET, fl2w(6'h01 << i) | RSV);
            rd_chk(LINK_SET_OFFSET);
            rd_chk(LINK_CLEAR_OFFSET);
        end
        rd_chk(IR_FILTER_OFFSET);
        wr(LINK_CLEAR_OFFSET, 32'hFFFFFFFF);
        rd_chk(LINK_CLEAR_OFFSET);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd_chk(LINK_SET_OFFSET);
        global_reset <= 1'b1;
        @(posedge ref_clk);
        global_reset <= 1'b0;
        @(posedge ref_clk);
        rd_chk(LINK_SET_OFFSET);
        for (int k = 0; k < 4; k++) begin
            wr(LINK_CLEAR_OFFSET, 32'hFFFFFFFF);
            wr(LINK_SET_OFFSET, $random(seed) & 32'h00000600); // random PHY and self-ID receive enables
            repeat (40) @(posedge ref_clk);
        end
        wr(LINK_SET_OFFSET, 32'h00300000);
        w0 = n_wrap;
        s0 = n_send;
        repeat (33000) @(posedge ref_clk);
        chk(per, 3072 * REF_CLK_KHZ / TIMER_CLK_KHZ);
        chk(n_send - s0, n_wrap - w0);
        wr(LINK_CLEAR_OFFSET, 32'h00100000);
        repeat (100) @(posedge ref_clk);
        wr(LINK_SET_OFFSET, 32'h00100000);
        wr(LINK_CLEAR_OFFSET, 32'h00200000);
        repeat (2000) @(posedge ref_clk);
        s0 = n_send;
        cs_rx <= 1'b1;
        @(posedge ref_clk);
        cs_rx <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(off <= 12'h001, 1);
        chk(n_send, s0);
        wr(LINK_SET_OFFSET, 32'h00600000);
        repeat (1500) @(posedge ref_clk);
        s0 = n_send;
        ext_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(off <= 12'h002, 1);
        chk(n_send - s0, 1);
        ext_in <= 1'b0;
        ovl <= 1'b1;
        @(posedge ref_clk);
        m_fl[4] <= 1'b0;
        @(posedge ref_clk);
        rd_chk(LINK_SET_OFFSET);
        wr(LINK_SET_OFFSET, 32'h00200000);
        rd_chk(LINK_SET_OFFSET);
        ovl <= 1'b0;
        @(posedge ref_clk);
        wr(LINK_SET_OFFSET, 32'h00200000);
        rd_chk(LINK_CLEAR_OFFSET);
        end_sim();
    end
endmodule
`default_nettype wire
